// ---- inc/dmsd_map.vh ----
`ifndef DMSD_MAP_VH
`define DMSD_MAP_VH
// ****************************************
// Register byte offsets
// ****************************************
`define DMSD_ADR_CTRL   8'h00
`define DMSD_ADR_STAT   8'h04
`define DMSD_ADR_MAIN   8'h08
`define DMSD_ADR_SWAL   8'h0c
`define DMSD_ADR_REF    8'h10
// ****************************************
// Control and status bit positions
// ****************************************
`define DMSD_CTRL_EXT   0
`define DMSD_CTRL_RPT   1
`define DMSD_CTRL_GO    2
`define DMSD_STAT_LOAD  0
`define DMSD_STAT_BUSY  1
`define DMSD_STAT_SELN  2
// ****************************************
// Reset values and timing counts
// ****************************************
`define DMSD_CTRL_RST   2'h0
`define DMSD_PCLK_LAST  6'h3f
`define DMSD_SLOT_LAST  4'hf
`define DMSD_POR_CYC    16'hd000
`define DMSD_REF_MIN    11'h003
`endif

// ---- core/dmsd_prog_seq.v ----
`timescale 1ns/1ps
// Programming clock (ref/64) and eight-word read sequencer.
// One read cycle is 16 programming ticks, i.e. 1024 reference cycles.
`include "dmsd_map.vh"
module dmsd_prog_seq (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       start,
  output reg        busy,
  output reg  [2:0] word_idx,
  output reg        capture,
  output reg        done
);
  reg [5:0] div;
  reg       tick;
  reg [3:0] slot;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div      <= 6'h00;
      tick     <= 1'b0;
      slot     <= 4'h0;
      busy     <= 1'b0;
      word_idx <= 3'h0;
      capture  <= 1'b0;
      done     <= 1'b0;
    end else begin
      div     <= div + 6'h01;
      tick    <= (div == `DMSD_PCLK_LAST);
      capture <= 1'b0;
      done    <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          slot <= 4'h0;
        end
      end else if (tick) begin
        slot <= slot + 4'h1;
        if (!slot[0]) begin
          word_idx <= slot[3:1];
        end else begin
          capture <= 1'b1;
          if (slot == `DMSD_SLOT_LAST) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // dmsd_prog_seq

// ---- core/dmsd_swallow.v ----
`timescale 1ns/1ps
// Swallow and main counters, count-up form, driving the modulus control.
module dmsd_swallow (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       run,
  input  wire       reload,
  input  wire       pres_edge,
  input  wire [6:0] swal_val,
  input  wire [9:0] main_val,
  output reg        mod_ctrl,
  output reg        main_term
);
  reg  [6:0] swal_cnt;
  reg  [9:0] main_cnt;
  wire [9:0] main_last;

  assign main_last = main_val - 10'h001;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      swal_cnt  <= 7'h00;
      main_cnt  <= 10'h000;
      mod_ctrl  <= 1'b0;
      main_term <= 1'b0;
    end else begin
      main_term <= 1'b0;
      if (reload || !run) begin
        swal_cnt <= 7'h00;
        main_cnt <= 10'h000;
      end else if (pres_edge) begin
        if (main_cnt == main_last) begin
          main_cnt  <= 10'h000;
          swal_cnt  <= 7'h00;
          main_term <= 1'b1;
        end else begin
          main_cnt <= main_cnt + 10'h001;
          if (swal_cnt != swal_val)
            swal_cnt <= swal_cnt + 7'h01;
        end
      end
      // High selects N+1 until the swallow count is reached
      mod_ctrl <= run && (swal_cnt != swal_val);
    end
  end
endmodule // dmsd_swallow

// ---- core/dmsd_top.v ----
`timescale 1ns/1ps
`include "dmsd_map.vh"
// Function
// - Swallow counter output drives the prescaler modulus control.
// - Main counter steps with swallow counter; its end reloads both.
// - Counters may count up or down with equal cycle behaviour; both count up only here.
// - Modulus is N+1 until swallow count reached, then N.
// - One main cycle spans N times main plus swallow input pulses.
// - Modulus change must settle within N prescaler input cycles.
// - Swallow 7, main 10, reference 11 bits, loaded from words.
// - A setting is eight four-bit words addressed by word select.
// - Repeating internal mode starts a read every 1024 clock periods.
// - Internal read drives store select low and steps words 0 to 7.
// - Each nibble is captured midway through its word select slot.
// - Programming clock is the reference clock divided by 64.
// - Repeating mode reruns read cycles continuously.
// - One strobe pulse in single-shot mode gives one read cycle.
// - Store select returns high when a read cycle ends.
// - After power-up a read starts by itself after 53248 cycles.
// - Word 1 copies all latches into the counters at once in external mode; internal reads copy after word 8.
// - Reference ratio accepted from 6 to 4094 in steps of 2.
// - Reference division ratio is twice the programmed value.
// - Words 1-3 main, 4-5 swallow, 6-8 reference, low bits first.
module dmsd_top #(
  parameter [15:0] POR_WAIT = `DMSD_POR_CYC
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        wb_cyc,
  input  wire        wb_stb,
  input  wire        wb_we,
  input  wire [7:0]  wb_adr,
  input  wire [3:0]  wb_sel,
  input  wire [31:0] wb_dat_w,
  output reg  [31:0] wb_dat_r,
  output reg         wb_ack,
  input  wire        pres_out,
  output wire        mod_ctrl,
  output wire        div_out,
  output reg         ref_out,
  input  wire        program_strobe,
  output reg         store_select_n,
  input  wire        word_select_0_rx,
  input  wire        word_select_1_rx,
  input  wire        word_select_2_rx,
  output wire        word_select_0_tx,
  output wire        word_select_1_tx,
  output wire        word_select_2_tx,
  output reg         word_select_oe,
  input  wire        nibble_in_0,
  input  wire        nibble_in_1,
  input  wire        nibble_in_2,
  input  wire        nibble_in_3
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [7:0] pin_raw;
  reg  [7:0] pin_s1;
  reg  [7:0] pin_s2;
  reg        strobe_d;
  reg  [2:0] pres_s;

  // Nibble, address and strobe share one pipeline so they stay aligned
  assign pin_raw = {program_strobe,
                    word_select_2_rx, word_select_1_rx, word_select_0_rx,
                    nibble_in_3, nibble_in_2, nibble_in_1, nibble_in_0};

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1   <= 8'h00;
      pin_s2   <= 8'h00;
      strobe_d <= 1'b0;
      pres_s   <= 3'h0;
    end else begin
      pin_s1   <= pin_raw;
      pin_s2   <= pin_s1;
      strobe_d <= pin_s2[7];
      pres_s   <= {pres_s[1:0], pres_out};
    end
  end

  wire [3:0] nib_sync;
  wire [2:0] ws_sync;
  wire       strobe_rise;
  wire       strobe_fall;
  wire       pres_edge;

  assign nib_sync    = pin_s2[3:0];
  assign ws_sync     = pin_s2[6:4];
  assign strobe_rise = pin_s2[7] & ~strobe_d;
  assign strobe_fall = ~pin_s2[7] & strobe_d;
  assign pres_edge   = pres_s[1] & ~pres_s[2];

  // ****************************************
  // Register decode
  // ****************************************
  // One-hot register select, shared by the write and read paths
  function [4:0] reg_hit;
    input [7:0] adr;
    case (adr)
      `DMSD_ADR_CTRL: reg_hit = 5'h01;
      `DMSD_ADR_STAT: reg_hit = 5'h02;
      `DMSD_ADR_MAIN: reg_hit = 5'h04;
      `DMSD_ADR_SWAL: reg_hit = 5'h08;
      `DMSD_ADR_REF:  reg_hit = 5'h10;
      default:        reg_hit = 5'h00;
    endcase
  endfunction

  wire [4:0] hit;

  assign hit = reg_hit(wb_adr);

  // ****************************************
  // Control register and power-on delay
  // ****************************************
  reg  [1:0]  ctrl;
  reg         sw_go;
  reg  [15:0] por_cnt;
  reg         por_done;
  reg         por_fire;
  wire        ext_mode;
  wire        wb_req;
  wire        wb_wr;
  wire        wb_rd;

  assign ext_mode = ctrl[`DMSD_CTRL_EXT];
  assign wb_req   = wb_cyc & wb_stb & ~wb_ack;
  assign wb_wr    = wb_req & wb_we;
  assign wb_rd    = wb_req & ~wb_we;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl     <= `DMSD_CTRL_RST;
      sw_go    <= 1'b0;
      por_cnt  <= 16'h0000;
      por_done <= 1'b0;
      por_fire <= 1'b0;
    end else begin
      sw_go    <= 1'b0;
      por_fire <= 1'b0;
      if (wb_wr && wb_sel[0] && hit[0]) begin
        ctrl  <= wb_dat_w[1:0];
        sw_go <= wb_dat_w[`DMSD_CTRL_GO];
      end
      if (!por_done) begin
        por_cnt <= por_cnt + 16'h0001;
        if (por_cnt == POR_WAIT - 16'h0001) begin
          por_done <= 1'b1;
          por_fire <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Read sequencer
  // ****************************************
  wire       seq_busy;
  wire [2:0] seq_idx;
  wire       seq_cap;
  wire       seq_done;
  wire       seq_start;

  // A strobe arriving while a cycle runs is ignored
  assign seq_start = ~ext_mode & ~seq_busy &
                     (por_fire |
                      strobe_rise |
                      sw_go |
                      ctrl[`DMSD_CTRL_RPT]);

  dmsd_prog_seq u_seq (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .start    (seq_start),
    .busy     (seq_busy),
    .word_idx (seq_idx),
    .capture  (seq_cap),
    .done     (seq_done)
  );

  assign word_select_0_tx = seq_idx[0];
  assign word_select_1_tx = seq_idx[1];
  assign word_select_2_tx = seq_idx[2];

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      store_select_n <= 1'b1;
      word_select_oe <= 1'b0;
    end else begin
      store_select_n <= ~seq_busy;
      word_select_oe <= ~ext_mode;
    end
  end

  // ****************************************
  // Word latches
  // ****************************************
  reg  [9:0]  lat_main;
  reg  [6:0]  lat_swal;
  reg  [10:0] lat_ref;
  reg  [9:0]  next_main;
  reg  [6:0]  next_swal;
  reg  [10:0] next_ref;
  wire        cap;
  wire [2:0]  cap_idx;

  assign cap     = ext_mode ? strobe_fall : seq_cap;
  assign cap_idx = ext_mode ? ws_sync : seq_idx;

  always @* begin
    next_main = lat_main;
    next_swal = lat_swal;
    next_ref  = lat_ref;
    if (cap) begin
      case (cap_idx)
        3'h0: next_main[1:0]  = nib_sync[3:2];
        3'h1: next_main[5:2]  = nib_sync;
        3'h2: next_main[9:6]  = nib_sync;
        3'h3: next_swal[3:0]  = nib_sync;
        3'h4: next_swal[6:4]  = nib_sync[2:0];
        3'h5: next_ref[3:0]   = nib_sync;
        3'h6: next_ref[7:4]   = nib_sync;
        3'h7: next_ref[10:8]  = nib_sync[2:0];
        default: next_main = lat_main;
      endcase
    end
  end

  // ****************************************
  // Transfer from latches into counters
  // ****************************************
  reg  [9:0]  main_val;
  reg  [6:0]  swal_val;
  reg  [10:0] ref_val;
  reg         loaded;
  reg         reload;
  wire        xfer;

  assign xfer = ext_mode ? (cap && cap_idx == 3'h0)
                         : seq_done;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lat_main <= 10'h000;
      lat_swal <= 7'h00;
      lat_ref  <= 11'h000;
      main_val <= 10'h000;
      swal_val <= 7'h00;
      ref_val  <= 11'h000;
      loaded   <= 1'b0;
      reload   <= 1'b0;
    end else begin
      lat_main <= next_main;
      lat_swal <= next_swal;
      lat_ref  <= next_ref;
      reload   <= xfer;
      if (xfer) begin
        main_val <= next_main;
        swal_val <= next_swal;
        ref_val  <= next_ref;
        loaded   <= 1'b1;
      end
    end
  end

  // ****************************************
  // Dual-modulus counters
  // ****************************************
  dmsd_swallow u_swal (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .run       (loaded),
    .reload    (reload),
    .pres_edge (pres_edge),
    .swal_val  (swal_val),
    .main_val  (main_val),
    .mod_ctrl  (mod_ctrl),
    .main_term (div_out)
  );

  // ****************************************
  // Reference divider, ratio twice the value
  // ****************************************
  reg  [10:0] ref_cnt;
  wire [10:0] ref_eff;

  // Values below the minimum are raised to it
  assign ref_eff = (ref_val < `DMSD_REF_MIN) ? `DMSD_REF_MIN : ref_val;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt <= 11'h000;
      ref_out <= 1'b0;
    end else if (!loaded) begin
      ref_cnt <= 11'h000;
      ref_out <= 1'b0;
    end else if (reload) begin
      // Restart the count but keep the level, so no short half period
      ref_cnt <= 11'h000;
    end else if (ref_cnt == ref_eff - 11'h001) begin
      ref_cnt <= 11'h000;
      ref_out <= ~ref_out;
    end else begin
      ref_cnt <= ref_cnt + 11'h001;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  reg [31:0] next_dat_r;

  always @* begin
    next_dat_r = 32'h00000000;
    case (hit)
      5'h01:   next_dat_r = {30'h0, ctrl};
      5'h02:   next_dat_r = {29'h0, store_select_n, seq_busy, loaded};
      5'h04:   next_dat_r = {22'h0, main_val};
      5'h08:   next_dat_r = {25'h0, swal_val};
      5'h10:   next_dat_r = {21'h0, ref_val};
      default: next_dat_r = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack <= wb_req;
      if (wb_rd) begin
        wb_dat_r <= next_dat_r;
      end
    end
  end
endmodule // dmsd_top

// ---- bench/dmsd_asserts.sv ----
`timescale 1ns/1ps
module dmsd_asserts (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_ack,
  input wire logic        div_out,
  input wire logic        ref_out,
  input wire logic        store_select_n,
  input wire logic        word_select_0_tx,
  input wire logic        word_select_1_tx,
  input wire logic        word_select_2_tx,
  input wire logic        word_select_oe
);
  // ********
  // Helpers
  // ********
  logic [2:0]  ws;
  logic [10:0] low_n;
  assign ws = {word_select_2_tx, word_select_1_tx, word_select_0_tx};
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst || store_select_n) begin
      low_n <= 11'h000;
    end else begin
      low_n <= low_n + 11'h001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ********
  // Checks
  // ********
  ack_latency_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack too long");
  div_pulse_a: assert property (div_out |=> !div_out)
    else $error("div pulse too long");
  sel_drives_a: assert property (!store_select_n |-> word_select_oe)
    else $error("word select not driven");
  word_step_a: assert property (!store_select_n && $past(!store_select_n)
    && ws != $past(ws) |-> ws == $past(ws) + 3'h1)
    else $error("word select skipped");
  word_hold_a: assert property ($changed(ws) && !store_select_n
    |=> $stable(ws) [*8])
    else $error("word slot too short");
  sel_end_a: assert property ($rose(store_select_n) |-> $past(ws) == 3'h7)
    else $error("read ended early");
  read_len_a: assert property ($rose(store_select_n)
    |-> low_n >= 11'h380 && low_n <= 11'h410)
    else $error("read cycle length");
  ref_hold_a: assert property ($changed(ref_out) |=> $stable(ref_out) [*2])
    else $error("reference half period short");
  read_c: cover property ($fell(store_select_n));
  div_c: cover property (div_out);
  ref_c: cover property ($rose(ref_out));
endmodule // dmsd_asserts

bind dmsd_top dmsd_asserts dmsd_asserts_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_ack(wb_ack), .div_out(div_out), .ref_out(ref_out),
  .store_select_n(store_select_n), .word_select_0_tx(word_select_0_tx),
  .word_select_1_tx(word_select_1_tx), .word_select_2_tx(word_select_2_tx),
  .word_select_oe(word_select_oe)
);

// ---- bench/dmsd_far_model.sv ----
`timescale 1ns/1ps
module dmsd_far_model (
  input  wire logic        ref_clk,
  input  wire logic        mod_ctrl,
  input  wire logic        sel,
  input  wire logic [2:0]  ws,
  input  wire logic [31:0] tbl,
  output      logic        pres_out,
  output wire logic [3:0]  nib
);
  // ********
  // Prescaler, 10 or 11 clocks a period
  // ********
  logic [3:0] c = 4'h0;
  logic [3:0] last = 4'h0;
  always @(posedge ref_clk) begin
    c <= (c == 4'h9 && !mod_ctrl) || c == 4'ha ? 4'h0 : c + 4'h1;
    pres_out <= c < 4'h5;
  end
  // ********
  // Word store; released lines show the inverse
  // ********
  always @(posedge ref_clk) begin
    if (sel) begin
      last <= tbl[{ws, 2'b00} +: 4];
    end
  end
  assign nib = sel ? tbl[{ws, 2'b00} +: 4] : ~last;
endmodule // dmsd_far_model

// ---- bench/test_dmsd_top.sv ----
`timescale 1ns/1ps
`include "dmsd_map.vh"
module test_dmsd_top;
  // ********
  // Signals
  // ********
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic        program_strobe = 1'b0;
  logic        host_en = 1'b0;
  logic [2:0]  host_ws = 3'h0;
  logic [31:0] tbl = 32'h0;
  logic [31:0] wb_dat_r, q;
  logic        wb_ack, pres_out, mod_ctrl, div_out, ref_out, store_select_n;
  logic        tx0, tx1, tx2, word_select_oe;
  logic [2:0]  ws;
  logic [3:0]  nib;
  logic [15:0] rnd;
  int          bad_count, n_checks, cyc_n, m, a, r, old_m, n;
  assign ws = word_select_oe ? {tx2, tx1, tx0} : host_ws;
  always #25 ref_clk = ~ref_clk;
  dmsd_top #(.POR_WAIT(16'h0040)) dmsd_top_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'h1), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .pres_out(pres_out),
    .mod_ctrl(mod_ctrl), .div_out(div_out), .ref_out(ref_out),
    .program_strobe(program_strobe), .store_select_n(store_select_n),
    .word_select_0_rx(ws[0]), .word_select_1_rx(ws[1]),
    .word_select_2_rx(ws[2]), .word_select_0_tx(tx0),
    .word_select_1_tx(tx1), .word_select_2_tx(tx2),
    .word_select_oe(word_select_oe), .nibble_in_0(nib[0]),
    .nibble_in_1(nib[1]), .nibble_in_2(nib[2]), .nibble_in_3(nib[3])
  );
  dmsd_far_model dmsd_far_model_i (
    .ref_clk(ref_clk), .mod_ctrl(mod_ctrl), .sel(!store_select_n || host_en),
    .ws(ws), .tbl(tbl), .pres_out(pres_out), .nib(nib)
  );
  // ********
  // Tasks
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task finish_test;
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= ad;
    wb_dat_w <= d;
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input int e);
    wb(1'b0, ad, 32'h0);
    chk(q, 32'(e));
  endtask
  task wt(input logic v);
    n = 0;
    while (store_select_n !== v && n < 1200) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(store_select_n), 32'(v));
  endtask
  task pulse;
    @(posedge ref_clk);
    program_strobe <= 1'b1;
    repeat (8) @(posedge ref_clk);
    program_strobe <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task newset;
    rnd = lfsr(rnd);
    m = 3 + rnd % 12;
    rnd = lfsr(rnd);
    a = rnd % (m + 1);
    rnd = lfsr(rnd);
    r = 3 + rnd % 20;
    tbl <= {1'b0, r[10:0], 1'b0, a[6:0], m[9:0], 2'b00};
  endtask
  // Cycles between the second and third rise of a watched signal
  task per(input int s, input int e);
    int  k, c;
    logic p, v;
    k = 0;
    c = 0;
    p = 1'b1;
    while (k < 3 && c < 5000) begin
      @(posedge ref_clk);
      v = s == 0 ? div_out : s == 1 ? ref_out : !store_select_n;
      if (v && !p) k++;
      if (k == 2) c++;
      p = v;
    end
    chk(32'(c), 32'(e));
  endtask
  task loaded;
    wt(1'b1);
    rd(`DMSD_ADR_MAIN, m);
    rd(`DMSD_ADR_SWAL, a);
    rd(`DMSD_ADR_REF, r);
    per(0, 10 * m + a);
    per(1, 2 * r);
  endtask
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      finish_test;
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    rnd = 16'hd862;
    bad_count = 0;
    n_checks = 0;
    cyc_n = 0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk({store_select_n, wb_ack, mod_ctrl, div_out, ref_out}, 32'h10);
    newset;
    wt(1'b0);
    chk(32'(n >= 62 && n <= 72), 32'h1);
    rd(`DMSD_ADR_CTRL, 0);
    rd(8'h40, 0);
    loaded;
    rd(`DMSD_ADR_STAT, 5);
    wb(1'b1, `DMSD_ADR_MAIN, 32'h0);
    rd(`DMSD_ADR_MAIN, m);
    newset;
    pulse;
    wt(1'b0);
    loaded;
    newset;
    wb(1'b1, `DMSD_ADR_CTRL, 32'h4);
    rd(`DMSD_ADR_CTRL, 0);
    wt(1'b0);
    rd(`DMSD_ADR_STAT, 3);
    loaded;
    old_m = m;
    wb(1'b1, `DMSD_ADR_CTRL, 32'h1);
    newset;
    host_en <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      if (i == 0) rd(`DMSD_ADR_MAIN, old_m);
      host_ws <= 3'(i);
      repeat (8) @(posedge ref_clk);
      pulse;
    end
    host_en <= 1'b0;
    loaded;
    wb(1'b1, `DMSD_ADR_CTRL, 32'h2);
    per(2, 1024);
    wb(1'b1, `DMSD_ADR_CTRL, 32'h0);
    finish_test;
  end
endmodule // test_dmsd_top
